//--- rtl/open_loop_startup_params.svh
// Constants for the open-loop startup settings block.
// Assumes inclusion by bare name from rtl/.
`ifndef OPEN_LOOP_STARTUP_PARAMS_SVH
`define OPEN_LOOP_STARTUP_PARAMS_SVH
// =========================================
// Register map (byte addresses)
`define ADDR_W            8
`define REG_SETTINGS      8'h84
`define REG_CONTROL       8'h88
`define REG_STATUS        8'h8c
`define REG_FREQ          8'h90
`define SETTINGS_RST      32'h0000_0000
// =========================================
// Settings word fields
`define F_PARITY          31
`define F_DUTY            30:28
`define F_ILIM            27:23
`define F_ACC1            22:18
`define F_ACC2            17:13
`define F_THR             12:8
`define F_AUTO            7
`define F_FIRST0          6
`define F_MIND            5:2
`define F_CYC             1:0
// =========================================
// Control and status fields
`define C_START           0
`define C_STOP            1
`define C_BIDIR           2
`define C_RATE            7:4
`define S_PHASE           1:0
`define S_CYC             12:8
`define FREQ_RD           47:16
// =========================================
// Current cap coding
`define ILIM_STEP_MV      12'h064
`define ILIM_UNI_OFS_MV   12'h04b
`define ILIM_UNI_WRAP     5'h1b
`define ILIM_BI_MASK      5'h0f
// =========================================
// Units and timing
`define MHZ_PER_S_TO_NHZ_PER_MS 48'd1000
`define MHZ_TO_NHZ        48'd1000000
`define HZ_TO_NHZ         48'd1000000000
`define RAMP_TICK_NS      1000000
`define CLK_PERIOD_NS     5
`endif

//--- rtl/open_loop_startup_pkg.sv
// Types for the open-loop startup settings block.
// Assumes nothing beyond a SystemVerilog compiler.
package open_loop_startup_pkg;
   // =========================================
   // Sequencer phases
   typedef enum logic [1:0] {
      PH_IDLE, PH_RAMP, PH_TRANSFER, PH_CLOSED
   } phase_t;

   // All state of the block
   typedef struct packed {
      phase_t      phase;
      logic [31:0] settings;
      logic        bidir;
      logic [3:0]  init_rate;
      logic [31:0] tick_cnt;
      logic [47:0] freq_nhz;
      logic [47:0] quad_rate;
      logic [4:0]  cyc_cnt;
      logic [31:0] rd_data;
      logic        handoff;
      logic [6:0]  duty_cap;
      logic [11:0] cur_mv;
      logic [7:0]  min_duty;
   } state_t;
endpackage

//--- rtl/open_loop_startup_config.sv
// Open-loop startup settings word and the ramp sequencer it steers.
// Assumes a single 200 MHz clock; start, stop and motor feedback come
// from logic on the same clock.
//
// What this block does
// - Bits 30:28 cap open-loop duty at 10,15,20,25,30,40,50,100 percent.
// - Bits 27:23 set current cap, 0.1 V per code, less offset.
// - Offset 75 mV unidirectional wrapping after 1Ah; 0 V bidirectional after 0Fh.
// - Bits 22:18 pick linear ramp coefficient, 0.005 Hz/s up, 1Fh unlimited.
// - Bits 17:13 pick quadratic ramp coefficient on the same scale.
// - Bits 12:8 set handoff frequency, 1 Hz up to 600 Hz.
// - Bit 7 set hands off automatically, clear uses the frequency threshold.
// - Bit 6 clear starts at initial rate, set starts at 0 Hz.
// - Bits 5:2 set minimum operating duty, 0 up to 25 percent.
// - Bits 1:0 give 3, 6, 12 or 24 handoff cycles.
// - Four-bit initial cycle rate runs 0.05 Hz up to 200 Hz.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "open_loop_startup_params.svh"
`default_nettype none

module open_loop_startup_config #(
   parameter int RAMP_TICK_CYCLES = `RAMP_TICK_NS / `CLK_PERIOD_NS
) (
   input  wire logic                     i_clk,
   input  wire logic                     i_reset,
   input  wire logic [`ADDR_W-1:0]       i_addr,
   input  wire logic [31:0]              i_wr_data,
   input  wire logic                     i_wr,
   input  wire logic                     i_rd,
   input  wire logic                     i_bemf_ready,
   input  wire logic                     i_elec_cycle,
   output logic [31:0]                   o_rd_data,
   output open_loop_startup_pkg::phase_t o_phase,
   output logic                          o_open_loop,
   output logic                          o_handoff,
   output logic [47:0]                   o_freq_nhz,
   output logic [6:0]                    o_duty_cap_pct,
   output logic [11:0]                   o_current_cap_mv,
   output logic [7:0]                    o_min_duty_pm
);
   import open_loop_startup_pkg::*;

   // =========================================
   // Elaboration check
   // A zero tick count would stall the ramp for 2^32 cycles per step
   generate
      if (RAMP_TICK_CYCLES < 1) begin : g_bad_tick
         $error("RAMP_TICK_CYCLES must be at least one");
      end
   endgenerate

   // =========================================
   // Lookup tables
   // Open-loop duty cap in percent
   function automatic logic [6:0] duty_pct(input logic [2:0] c);
      case (c)
         3'h0: duty_pct = 7'h0a;
         3'h1: duty_pct = 7'h0f;
         3'h2: duty_pct = 7'h14;
         3'h3: duty_pct = 7'h19;
         3'h4: duty_pct = 7'h1e;
         3'h5: duty_pct = 7'h28;
         3'h6: duty_pct = 7'h32;
         default: duty_pct = 7'h64;
      endcase
   endfunction

   // Minimum duty in tenths of a percent
   // Tenths keep the 1.5 and 17.5 percent steps exact
   function automatic logic [7:0] min_pm(input logic [3:0] c);
      case (c)
         4'h0: min_pm = 8'h00;
         4'h1: min_pm = 8'h0f;
         4'h2: min_pm = 8'h19;
         4'h3: min_pm = 8'h1e;
         4'h4: min_pm = 8'h28;
         4'h5: min_pm = 8'h32;
         4'h6: min_pm = 8'h3c;
         4'h7: min_pm = 8'h46;
         4'h8: min_pm = 8'h50;
         4'h9: min_pm = 8'h5a;
         4'ha: min_pm = 8'h64;
         4'hb: min_pm = 8'h78;
         4'hc: min_pm = 8'h96;
         4'hd: min_pm = 8'haf;
         4'he: min_pm = 8'hc8;
         default: min_pm = 8'hfa;
      endcase
   endfunction

   // Ramp coefficient in mHz/s (or mHz/s2)
   function automatic logic [47:0] acc_mhz(input logic [4:0] c);
      case (c)
         5'h00: acc_mhz = 48'h5;
         5'h01: acc_mhz = 48'ha;
         5'h02: acc_mhz = 48'h19;
         5'h03: acc_mhz = 48'h32;
         5'h04: acc_mhz = 48'h64;
         5'h05: acc_mhz = 48'hfa;
         5'h06: acc_mhz = 48'h1f4;
         5'h07: acc_mhz = 48'h3e8;
         5'h08: acc_mhz = 48'h9c4;
         5'h09: acc_mhz = 48'h1388;
         5'h0a: acc_mhz = 48'h1d4c;
         5'h0b: acc_mhz = 48'h2710;
         5'h0c: acc_mhz = 48'h30d4;
         5'h0d: acc_mhz = 48'h3a98;
         5'h0e: acc_mhz = 48'h4e20;
         5'h0f: acc_mhz = 48'h7530;
         5'h10: acc_mhz = 48'h9c40;
         5'h11: acc_mhz = 48'hc350;
         5'h12: acc_mhz = 48'hea60;
         5'h13: acc_mhz = 48'h124f8;
         5'h14: acc_mhz = 48'h186a0;
         5'h15: acc_mhz = 48'h1e848;
         5'h16: acc_mhz = 48'h249f0;
         5'h17: acc_mhz = 48'h2ab98;
         5'h18: acc_mhz = 48'h30d40;
         5'h19: acc_mhz = 48'h3d090;
         5'h1a: acc_mhz = 48'h493e0;
         5'h1b: acc_mhz = 48'h61a80;
         5'h1c: acc_mhz = 48'h7a120;
         5'h1d: acc_mhz = 48'hb71b0;
         5'h1e: acc_mhz = 48'hf4240;
         default: acc_mhz = 48'h1f3fc18; // No limit
      endcase
   endfunction

   // Handoff threshold in Hz
   // Codes 19h to 1Fh step by 50 Hz between 300 and 600 Hz
   function automatic logic [47:0] thr_hz(input logic [4:0] c);
      case (c)
         5'h00: thr_hz = 48'h1;
         5'h01: thr_hz = 48'h4;
         5'h02: thr_hz = 48'h8;
         5'h03: thr_hz = 48'hc;
         5'h04: thr_hz = 48'h10;
         5'h05: thr_hz = 48'h14;
         5'h06: thr_hz = 48'h18;
         5'h07: thr_hz = 48'h1c;
         5'h08: thr_hz = 48'h20;
         5'h09: thr_hz = 48'h24;
         5'h0a: thr_hz = 48'h28;
         5'h0b: thr_hz = 48'h2d;
         5'h0c: thr_hz = 48'h32;
         5'h0d: thr_hz = 48'h37;
         5'h0e: thr_hz = 48'h3c;
         5'h0f: thr_hz = 48'h41;
         5'h10: thr_hz = 48'h46;
         5'h11: thr_hz = 48'h4b;
         5'h12: thr_hz = 48'h50;
         5'h13: thr_hz = 48'h55;
         5'h14: thr_hz = 48'h5a;
         5'h15: thr_hz = 48'h64;
         5'h16: thr_hz = 48'h96;
         5'h17: thr_hz = 48'hc8;
         5'h18: thr_hz = 48'hfa;
         5'h19: thr_hz = 48'h12c;
         5'h1a: thr_hz = 48'h15e;
         5'h1b: thr_hz = 48'h190;
         5'h1c: thr_hz = 48'h1c2;
         5'h1d: thr_hz = 48'h1f4;
         5'h1e: thr_hz = 48'h226;
         default: thr_hz = 48'h258;
      endcase
   endfunction

   // Initial cycle rate in mHz
   // Code Ah sits at 20 Hz, between its neighbours
   function automatic logic [47:0] init_mhz(input logic [3:0] c);
      case (c)
         4'h0: init_mhz = 48'h32;
         4'h1: init_mhz = 48'h64;
         4'h2: init_mhz = 48'hfa;
         4'h3: init_mhz = 48'h1f4;
         4'h4: init_mhz = 48'h3e8;
         4'h5: init_mhz = 48'h7d0;
         4'h6: init_mhz = 48'hbb8;
         4'h7: init_mhz = 48'h1388;
         4'h8: init_mhz = 48'h2710;
         4'h9: init_mhz = 48'h3a98;
         4'ha: init_mhz = 48'h4e20;
         4'hb: init_mhz = 48'h61a8;
         4'hc: init_mhz = 48'hc350;
         4'hd: init_mhz = 48'h186a0;
         4'he: init_mhz = 48'h249f0;
         default: init_mhz = 48'h30d40;
      endcase
   endfunction

   // Handoff cycle count
   function automatic logic [4:0] cyc_need(input logic [1:0] c);
      case (c)
         2'h0: cyc_need = 5'h03;
         2'h1: cyc_need = 5'h06;
         2'h2: cyc_need = 5'h0c;
         default: cyc_need = 5'h18;
      endcase
   endfunction

   // =========================================
   // State
   state_t s_reg;
   state_t s_next;
   logic [4:0]  ilim_code;
   logic [11:0] ilim_mv;
   logic        at_thr;
   logic        tick;

   // Current cap with rollover and offset
   // Unidirectional codes past the wrap fold back; the offset clamps at zero
   always_comb begin
      ilim_code = s_reg.settings[`F_ILIM];
      if (s_reg.bidir) begin
         ilim_code = ilim_code & `ILIM_BI_MASK;
      end else if (ilim_code >= `ILIM_UNI_WRAP) begin
         ilim_code = ilim_code - `ILIM_UNI_WRAP;
      end
      ilim_mv = 12'(ilim_code * `ILIM_STEP_MV);
      if (!s_reg.bidir) begin
         ilim_mv = (ilim_mv > `ILIM_UNI_OFS_MV) ? ilim_mv - `ILIM_UNI_OFS_MV : 12'h000;
      end
   end

   // Threshold compare and ramp tick
   // Threshold widened to nano-Hz so it compares with the ramp directly
   assign at_thr = s_reg.freq_nhz >= 48'(thr_hz(s_reg.settings[`F_THR]) * `HZ_TO_NHZ);
   assign tick   = s_reg.tick_cnt == 32'(RAMP_TICK_CYCLES - 1);

   // Next state: register port and sequencer
   // A start while busy is ignored; stop is applied last so it wins
   always_comb begin
      s_next = s_reg;
      s_next.handoff = 1'b0;
      s_next.rd_data = 32'h0000_0000;
      // Reads answer one cycle later
      if (i_rd) begin
         case (i_addr)
            `REG_SETTINGS: s_next.rd_data = s_reg.settings;
            `REG_CONTROL: begin
               s_next.rd_data[`C_BIDIR] = s_reg.bidir;
               s_next.rd_data[`C_RATE]  = s_reg.init_rate;
            end
            `REG_STATUS: begin
               s_next.rd_data[`S_PHASE] = s_reg.phase;
               s_next.rd_data[`S_CYC]   = s_reg.cyc_cnt;
            end
            `REG_FREQ: s_next.rd_data = s_reg.freq_nhz[`FREQ_RD];
            default: s_next.rd_data = 32'h0000_0000;
         endcase
      end
      // Writes; parity bit stored as written
      if (i_wr && i_addr == `REG_SETTINGS) begin
         s_next.settings = i_wr_data;
      end
      if (i_wr && i_addr == `REG_CONTROL) begin
         s_next.bidir     = i_wr_data[`C_BIDIR];
         s_next.init_rate = i_wr_data[`C_RATE];
      end
      // Sequencer
      case (s_reg.phase)
         PH_IDLE: begin
            if (i_wr && i_addr == `REG_CONTROL && i_wr_data[`C_START]) begin
               s_next.phase     = PH_RAMP;
               s_next.tick_cnt  = 32'h0;
               s_next.quad_rate = 48'h0;
               s_next.cyc_cnt   = 5'h00;
               if (s_reg.settings[`F_FIRST0]) begin
                  s_next.freq_nhz = 48'h0;
               end else begin
                  s_next.freq_nhz = 48'(init_mhz(s_reg.init_rate) * `MHZ_TO_NHZ);
               end
            end
         end
         PH_RAMP: begin
            s_next.tick_cnt = tick ? 32'h0 : s_reg.tick_cnt + 32'h1;
            if (tick) begin
               // Linear term plus growing quadratic term each tick
               s_next.freq_nhz = s_reg.freq_nhz
                  + 48'(acc_mhz(s_reg.settings[`F_ACC1]) * `MHZ_PER_S_TO_NHZ_PER_MS)
                  + s_reg.quad_rate;
               s_next.quad_rate = s_reg.quad_rate
                  + acc_mhz(s_reg.settings[`F_ACC2]);
            end
            // Handoff condition is checked every cycle, not only on ticks
            if (s_reg.settings[`F_AUTO] ? i_bemf_ready : at_thr) begin
               s_next.phase   = PH_TRANSFER;
               s_next.cyc_cnt = 5'h00;
            end
         end
         PH_TRANSFER: begin
            // Electrical cycles count only while transferring
            if (i_elec_cycle) begin
               s_next.cyc_cnt = s_reg.cyc_cnt + 5'h01;
               if (s_reg.cyc_cnt + 5'h01 == cyc_need(s_reg.settings[`F_CYC])) begin
                  s_next.phase   = PH_CLOSED;
                  s_next.handoff = 1'b1;
               end
            end
         end
         PH_CLOSED: s_next.phase = PH_CLOSED;
         default: s_next.phase = PH_IDLE;
      endcase
      // Stop wins over everything, a handoff pulse included
      if (i_wr && i_addr == `REG_CONTROL && i_wr_data[`C_STOP]) begin
         s_next.phase    = PH_IDLE;
         s_next.handoff  = 1'b0; // No handoff report from a stopped motor
         s_next.freq_nhz = 48'h0;
         s_next.tick_cnt = 32'h0;
      end
      // Decoded limits for the drive stage
      // Registered, so limits settle one cycle after the word is written
      s_next.duty_cap = duty_pct(s_reg.settings[`F_DUTY]);
      s_next.cur_mv   = ilim_mv;
      s_next.min_duty = min_pm(s_reg.settings[`F_MIND]);
   end

   // State register; everything clears to zero
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // =========================================
   // Outputs
   // Open-loop flag follows the registered phase
   assign o_rd_data        = s_reg.rd_data;
   assign o_phase          = s_reg.phase;
   assign o_open_loop      = s_reg.phase == PH_RAMP || s_reg.phase == PH_TRANSFER;
   assign o_handoff        = s_reg.handoff;
   assign o_freq_nhz       = s_reg.freq_nhz;
   assign o_duty_cap_pct   = s_reg.duty_cap;
   assign o_current_cap_mv = s_reg.cur_mv;
   assign o_min_duty_pm    = s_reg.min_duty;
endmodule

`default_nettype wire

//--- tb/open_loop_startup_props.sv
// Checker for the open-loop startup settings block.
// Assumes it is bound to open_loop_startup_config and sees its ports only.
`timescale 1ns/1ps
`include "open_loop_startup_params.svh"
`default_nettype none
module open_loop_startup_props
   import open_loop_startup_pkg::*;
#(
   parameter int RAMP_TICK_CYCLES = 4
) (
   input wire logic               i_clk,
   input wire logic               i_reset,
   input wire logic [`ADDR_W-1:0] i_addr,
   input wire logic [31:0]        i_wr_data,
   input wire logic               i_wr,
   input wire logic               i_rd,
   input wire logic               i_bemf_ready,
   input wire logic               i_elec_cycle,
   input wire logic [31:0]        o_rd_data,
   input wire phase_t             o_phase,
   input wire logic               o_open_loop,
   input wire logic               o_handoff,
   input wire logic [47:0]        o_freq_nhz,
   input wire logic [6:0]         o_duty_cap_pct,
   input wire logic [11:0]        o_current_cap_mv,
   input wire logic [7:0]         o_min_duty_pm
);
   // =========================================
   // Decode tables and shared sequences
   localparam logic [6:0] DUTY [8] = '{7'h0a, 7'h0f, 7'h14, 7'h19, 7'h1e, 7'h28, 7'h32, 7'h64};
   localparam logic [7:0] MIND [16] = '{8'h00, 8'h0f, 8'h19, 8'h1e, 8'h28, 8'h32, 8'h3c,
      8'h46, 8'h50, 8'h5a, 8'h64, 8'h78, 8'h96, 8'haf, 8'hc8, 8'hfa};
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence s_set_wr;
      i_wr && i_addr == `REG_SETTINGS;
   endsequence
   sequence s_set_once;
      s_set_wr ##1 !(i_wr && i_addr == `REG_SETTINGS);
   endsequence
   // =========================================
   // Assertions
   a_duty_follow: assert property (s_set_once |=>
      o_duty_cap_pct == DUTY[$past(i_wr_data[`F_DUTY], 2)]) else $error("duty cap wrong");
   a_mind_follow: assert property (s_set_once |=>
      o_min_duty_pm == MIND[$past(i_wr_data[`F_MIND], 2)]) else $error("min duty wrong");
   a_word_readback: assert property (s_set_wr ##1 (i_rd && i_addr == `REG_SETTINGS)
      |=> o_rd_data == $past(i_wr_data, 2)) else $error("settings readback wrong");
   a_handoff_short: assert property (o_handoff |=> !o_handoff)
      else $error("handoff pulse too long");
   a_handoff_entry: assert property (o_handoff |-> o_phase == PH_CLOSED
      && $past(o_phase) == PH_TRANSFER && $past(i_elec_cycle)) else $error("bad handoff");
   a_open_level: assert property (o_open_loop == (o_phase inside {PH_RAMP, PH_TRANSFER}))
      else $error("open loop flag wrong");
   a_transfer_src: assert property ((o_phase == PH_TRANSFER && $past(o_phase) != PH_TRANSFER)
      |-> $past(o_phase) == PH_RAMP) else $error("transfer not from ramp");
   a_stop_idle: assert property (i_wr && i_addr == `REG_CONTROL && i_wr_data[`C_STOP]
      |=> o_phase == PH_IDLE && o_freq_nhz == 48'h0) else $error("stop not honoured");
endmodule
bind open_loop_startup_config open_loop_startup_props #(.RAMP_TICK_CYCLES(RAMP_TICK_CYCLES)) u_props (
   .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
   .i_rd(i_rd), .i_bemf_ready(i_bemf_ready), .i_elec_cycle(i_elec_cycle), .o_rd_data(o_rd_data),
   .o_phase(o_phase), .o_open_loop(o_open_loop), .o_handoff(o_handoff), .o_freq_nhz(o_freq_nhz),
   .o_duty_cap_pct(o_duty_cap_pct), .o_current_cap_mv(o_current_cap_mv),
   .o_min_duty_pm(o_min_duty_pm));
`default_nettype wire

//--- tb/open_loop_startup_config_test.sv
// Self-checking bench for the open-loop startup settings block.
// Assumes the rtl/ files and the checker are compiled before it.
`timescale 1ns/1ps
`include "open_loop_startup_params.svh"
`default_nettype none
module open_loop_startup_config_test;
   import open_loop_startup_pkg::*;
   logic               i_clk, i_reset, i_wr, i_rd, i_bemf_ready, i_elec_cycle;
   logic [`ADDR_W-1:0] i_addr;
   logic [31:0]        i_wr_data, o_rd_data, d;
   phase_t             o_phase;
   logic               o_open_loop, o_handoff;
   logic [47:0]        o_freq_nhz;
   logic [6:0]         o_duty_cap_pct;
   logic [11:0]        o_current_cap_mv;
   logic [7:0]         o_min_duty_pm;
   int                 fails, checks, k, j, n;
   localparam logic [6:0] DUTY [8] = '{7'h0a, 7'h0f, 7'h14, 7'h19, 7'h1e, 7'h28, 7'h32, 7'h64};
   localparam logic [7:0] MIND [16] = '{8'h00, 8'h0f, 8'h19, 8'h1e, 8'h28, 8'h32, 8'h3c,
      8'h46, 8'h50, 8'h5a, 8'h64, 8'h78, 8'h96, 8'haf, 8'hc8, 8'hfa};

   // Short ramp tick keeps the run brief
   open_loop_startup_config #(.RAMP_TICK_CYCLES(4)) dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
      .i_rd(i_rd), .i_bemf_ready(i_bemf_ready), .i_elec_cycle(i_elec_cycle),
      .o_rd_data(o_rd_data), .o_phase(o_phase), .o_open_loop(o_open_loop),
      .o_handoff(o_handoff), .o_freq_nhz(o_freq_nhz), .o_duty_cap_pct(o_duty_cap_pct),
      .o_current_cap_mv(o_current_cap_mv), .o_min_duty_pm(o_min_duty_pm));

   // 200 MHz clock
   always #2.5 i_clk = ~i_clk;

   // =========================================
   // Expectations and bus tasks
   function automatic logic [11:0] cur_exp(input logic [4:0] c, input logic bi);
      logic [11:0] v;
      if (bi) begin
         v = 12'(c[3:0]) * 12'h064;
      end else begin
         v = 12'(c >= 5'h1b ? c - 5'h1b : c) * 12'h064;
         v = v > 12'h04b ? v - 12'h04b : 12'h000;
      end
      return v;
   endfunction

   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Ends off the edge so writes may follow with no gap
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wr_data <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rd_data, exp);
   endtask

   task automatic settle;
      @(posedge i_clk);
      #1;
   endtask

   task automatic wait_phase(input phase_t p);
      n = 0;
      while (o_phase !== p && n < 50) begin
         settle();
         n++;
      end
   endtask

   task automatic print_verdict;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #50000;
      fails++;
      print_verdict();
   end

   // =========================================
   // Main sequence
   initial begin
      i_clk = 1'b0;
      i_reset = 1'b1;
      {i_wr, i_rd, i_bemf_ready, i_elec_cycle, i_addr, i_wr_data} = '0;
      void'($urandom(32'hb872));
      repeat (2) @(posedge i_clk);
      i_reset <= 1'b0;
      settle();
      chk(o_duty_cap_pct, 7'h0a);
      rd(`REG_SETTINGS, 32'h0);
      // Random words with every duty and minimum-duty code, both amplifier modes
      for (k = 0; k < 32; k++) begin
         d = $urandom;
         d[30:28] = k[2:0];
         d[5:2] = k[3:0];
         wr(`REG_CONTROL, k[4] ? 32'h4 : 32'h0);
         wr(`REG_SETTINGS, d);
         rd(`REG_SETTINGS, d);
         chk(o_duty_cap_pct, DUTY[k[2:0]]);
         chk(o_min_duty_pm, MIND[k[3:0]]);
         chk(o_current_cap_mv, cur_exp(d[27:23], k[4]));
      end
      // Unmapped place: write ignored, read zero
      wr(8'h00, 32'hffff_ffff);
      rd(`REG_SETTINGS, d);
      rd(8'h00, 32'h0);
      // Start from 0 Hz, 1 Hz threshold, fastest ramp; each handoff count
      for (k = 0; k < 4; k++) begin
         wr(`REG_CONTROL, 32'h2);
         wr(`REG_SETTINGS, 32'h007c_0040 | 32'(k));
         wr(`REG_CONTROL, 32'h1);
         chk(o_phase, PH_RAMP);
         chk(o_freq_nhz, 48'h0);
         wait_phase(PH_TRANSFER);
         chk(o_phase, PH_TRANSFER);
         chk(o_freq_nhz, 48'd32767 * `HZ_TO_NHZ / 48'd1000);
         for (j = 0; j < (3 << k); j++) begin
            chk(o_phase, PH_TRANSFER);
            i_elec_cycle <= 1'b1;
            @(posedge i_clk);
            i_elec_cycle <= 1'b0;
            #1;
            if (j < (3 << k) - 1)
               settle();
         end
         chk(o_phase, PH_CLOSED);
         chk(o_handoff, 1'b1);
         rd(`REG_STATUS, (32'(3 << k) << 8) | 32'h3);
      end
      // Initial rate code 4 is 1 Hz; 600 Hz threshold keeps it ramping
      wr(`REG_CONTROL, 32'h42);
      wr(`REG_SETTINGS, 32'h0000_1f00);
      wr(`REG_CONTROL, 32'h41);
      chk(o_freq_nhz, 48'h0000_3b9a_ca00);
      chk(o_open_loop, 1'b1);
      rd(`REG_FREQ, 32'(48'd1000 * `MHZ_TO_NHZ >> 16));
      rd(`REG_CONTROL, 32'h40);
      rd(`REG_STATUS, 32'h1);
      repeat (20) settle();
      chk(o_freq_nhz > 48'h0000_3b9a_ca00, 1'b1);
      // Automatic handoff waits for back-EMF only
      wr(`REG_SETTINGS, 32'h0000_1f80);
      repeat (3) settle();
      chk(o_phase, PH_RAMP);
      i_bemf_ready <= 1'b1;
      settle();
      chk(o_phase, PH_TRANSFER);
      i_bemf_ready <= 1'b0;
      wr(`REG_CONTROL, 32'h2);
      chk(o_phase, PH_IDLE);
      chk(o_freq_nhz, 48'h0);
      // Reset after the stop, in idle, clears the stored word
      i_reset <= 1'b1;
      settle();
      i_reset <= 1'b0;
      settle();
      rd(`REG_SETTINGS, 32'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
